// >>> hw/chgcfg_pkg.sv
package chgcfg_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  CTRL_PRI_ADDR   = 8'h0a;
  localparam logic [7:0]  CTRL_SEC_ADDR   = 8'h0b;
  localparam logic [7:0]  TIMER_ADDR      = 8'h0c;
  localparam logic [7:0]  CTRL_PRI_RST    = 8'h00;
  localparam logic [7:0]  CTRL_SEC_RST    = 8'h00;
  localparam logic [7:0]  TIMER_RST       = 8'h00;
  localparam logic [7:0]  CTRL_SEC_MASK   = 8'h7f;
  localparam logic [7:0]  TIMER_MASK      = 8'h3f;
  localparam int          AUTO_STOP_BIT   = 7;
  localparam int          AUTO_RESTART_BIT = 6;
  localparam int          RECHG_LSB       = 4;
  localparam int          BATTERY_REGULATION_SEL_LSB      = 1;
  localparam int          CHARGER_ON_BIT  = 0;
  localparam int          PREV_LSB        = 4;
  localparam int          PREI_LSB        = 2;
  localparam int          DONE_LSB        = 0;
  localparam int          MT_TMR_LSB      = 4;
  localparam int          FC_TMR_LSB      = 2;
  localparam int          PC_TMR_LSB      = 0;
  localparam logic [2:0]  BATTERY_REGULATION_SEL_RSVD     = 3'h7;
  // regulation in mV: 4050 + 50 * code
  localparam logic [12:0] BATTERY_REGULATION_SEL_BASE_MV  = 13'h0fd2;
  localparam logic [12:0] BATTERY_REGULATION_SEL_STEP_MV  = 13'h0032;
  // pre-charge threshold in mV: 2100 + 150 * code
  localparam logic [12:0] PREV_BASE_MV    = 13'h0834;
  localparam logic [12:0] PREV_STEP_MV    = 13'h0096;
  // current ratios in hundredths of fast-charge current: 5,10,20,30
  localparam logic [5:0]  RATIO_0         = 6'h05;
  localparam logic [5:0]  RATIO_1         = 6'h0a;
  localparam logic [5:0]  RATIO_2         = 6'h14;
  localparam logic [5:0]  RATIO_3         = 6'h1e;
  // timer minutes
  localparam logic [9:0]  MT_MIN_0        = 10'h000;
  localparam logic [9:0]  MT_MIN_1        = 10'h00f;
  localparam logic [9:0]  MT_MIN_2        = 10'h01e;
  localparam logic [9:0]  MT_MIN_3        = 10'h03c;
  localparam logic [9:0]  FC_MIN_BASE     = 10'h04b;
  localparam logic [9:0]  PC_MIN_BASE     = 10'h01e;
endpackage

// >>> hw/chgcfg_edge_if.sv
`timescale 1ns/100ps
`default_nettype none
interface chgcfg_edge_if;
  logic level;
  logic rise;
  modport det (input level, output rise);
  modport use_side (output level, input rise);
endinterface
`default_nettype wire

// >>> hw/chgcfg_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none
module chgcfg_sync_edge (
  input  wire logic   i_clk,
  input  wire logic   i_reset_n,
  input  wire logic   i_ce,
  chgcfg_edge_if.det  edge_io
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic rise_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      rise_r <= 1'b0;
    end else if (i_ce) begin
      meta_r <= edge_io.level;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise_r <= sync_r & ~prev_r;
    end
  end

  assign edge_io.rise = rise_r & i_ce;
endmodule
`default_nettype wire

// >>> hw/chgcfg_regs.sv
`timescale 1ns/100ps
`default_nettype none
module chgcfg_regs (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET_N,
  input  wire logic        I_CE,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic        I_WRITE_PROTECT,
  input  wire logic        I_CHARGER_INPUT_SUPPLY,
  output logic      [7:0]  O_RDATA,
  output logic             O_AUTO_STOP_ENABLE,
  output logic             O_AUTO_RESTART_ENABLE,
  output logic      [1:0]  O_RECHARGE_THRESHOLD_SEL,
  output logic             O_BATTERY_REGULATION_SEL_VALID,
  output logic     [12:0]  O_BATTERY_REGULATION_SEL_MV,
  output logic             O_CHARGER_ON,
  output logic     [12:0]  O_PRECHARGE_MV,
  output logic      [5:0]  O_PRECHARGE_PCT,
  output logic      [5:0]  O_DONE_PCT,
  output logic      [9:0]  O_MAINTAIN_MIN,
  output logic      [9:0]  O_FAST_MIN,
  output logic      [9:0]  O_PRE_MIN
);
  logic [7:0] ctrl_pri_r;
  logic [7:0] ctrl_sec_r;
  logic [7:0] timer_r;
  logic       wp_meta_r;
  logic       wp_r;
  logic       supply_rise;
  logic [2:0] battery_regulation_sel_code;
  logic [2:0] prev_code;

  chgcfg_edge_if supply_if ();
  assign supply_if.level = I_CHARGER_INPUT_SUPPLY;
  assign supply_rise     = supply_if.rise;

  chgcfg_sync_edge u_supply_edge (
    .i_clk     (I_CLK_SYS),
    .i_reset_n (I_RESET_N),
    .i_ce      (I_CE),
    .edge_io   (supply_if.det)
  );

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wp_meta_r <= 1'b0;
      wp_r      <= 1'b0;
    end else if (I_CE) begin
      wp_meta_r <= I_WRITE_PROTECT;
      wp_r      <= wp_meta_r;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_pri_r <= chgcfg_pkg::CTRL_PRI_RST;
    end else if (I_CE) begin
      if (supply_rise) begin
        ctrl_pri_r <= chgcfg_pkg::CTRL_PRI_RST;
      end else if (I_WR && I_ADDR == chgcfg_pkg::CTRL_PRI_ADDR && !wp_r) begin
        ctrl_pri_r <= I_WDATA;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_sec_r <= chgcfg_pkg::CTRL_SEC_RST;
      timer_r    <= chgcfg_pkg::TIMER_RST;
    end else if (I_CE) begin
      if (supply_rise) begin
        ctrl_sec_r <= chgcfg_pkg::CTRL_SEC_RST;
        timer_r    <= chgcfg_pkg::TIMER_RST;
      end else if (I_WR) begin
        if (I_ADDR == chgcfg_pkg::CTRL_SEC_ADDR) begin
          ctrl_sec_r <= I_WDATA & chgcfg_pkg::CTRL_SEC_MASK;
        end
        if (I_ADDR == chgcfg_pkg::TIMER_ADDR) begin
          timer_r <= I_WDATA & chgcfg_pkg::TIMER_MASK;
        end
      end
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
    end else if (I_CE) begin
      if (I_RD) begin
        unique case (I_ADDR)
          chgcfg_pkg::CTRL_PRI_ADDR: O_RDATA <= ctrl_pri_r;
          chgcfg_pkg::CTRL_SEC_ADDR: O_RDATA <= ctrl_sec_r;
          chgcfg_pkg::TIMER_ADDR:    O_RDATA <= timer_r;
          default:                   O_RDATA <= 8'h00;
        endcase
      end else begin
        O_RDATA <= 8'h00;
      end
    end
  end

  assign battery_regulation_sel_code = ctrl_pri_r[chgcfg_pkg::BATTERY_REGULATION_SEL_LSB +: 3];
  assign prev_code   = ctrl_sec_r[chgcfg_pkg::PREV_LSB +: 3];

  function automatic logic [5:0] ratio(input logic [1:0] code);
    unique case (code)
      2'h0: ratio = chgcfg_pkg::RATIO_0;
      2'h1: ratio = chgcfg_pkg::RATIO_1;
      2'h2: ratio = chgcfg_pkg::RATIO_2;
      2'h3: ratio = chgcfg_pkg::RATIO_3;
    endcase
  endfunction

  function automatic logic [9:0] mt_min(input logic [1:0] code);
    unique case (code)
      2'h0: mt_min = chgcfg_pkg::MT_MIN_0;
      2'h1: mt_min = chgcfg_pkg::MT_MIN_1;
      2'h2: mt_min = chgcfg_pkg::MT_MIN_2;
      2'h3: mt_min = chgcfg_pkg::MT_MIN_3;
    endcase
  endfunction

  // decoded settings for the charger state machine
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_AUTO_STOP_ENABLE       <= 1'b0;
      O_AUTO_RESTART_ENABLE    <= 1'b0;
      O_RECHARGE_THRESHOLD_SEL <= 2'h0;
      O_CHARGER_ON             <= 1'b0;
      O_BATTERY_REGULATION_SEL_VALID           <= 1'b1;
      O_BATTERY_REGULATION_SEL_MV              <= chgcfg_pkg::BATTERY_REGULATION_SEL_BASE_MV;
    end else if (I_CE) begin
      O_AUTO_STOP_ENABLE       <= ctrl_pri_r[chgcfg_pkg::AUTO_STOP_BIT];
      O_AUTO_RESTART_ENABLE    <= ctrl_pri_r[chgcfg_pkg::AUTO_RESTART_BIT];
      O_RECHARGE_THRESHOLD_SEL <= ctrl_pri_r[chgcfg_pkg::RECHG_LSB +: 2];
      O_CHARGER_ON             <= ctrl_pri_r[chgcfg_pkg::CHARGER_ON_BIT];
      O_BATTERY_REGULATION_SEL_VALID           <= battery_regulation_sel_code != chgcfg_pkg::BATTERY_REGULATION_SEL_RSVD;
      O_BATTERY_REGULATION_SEL_MV              <= 13'(chgcfg_pkg::BATTERY_REGULATION_SEL_BASE_MV
                                  + chgcfg_pkg::BATTERY_REGULATION_SEL_STEP_MV * 13'(battery_regulation_sel_code));
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PRECHARGE_MV  <= chgcfg_pkg::PREV_BASE_MV;
      O_PRECHARGE_PCT <= chgcfg_pkg::RATIO_0;
      O_DONE_PCT      <= chgcfg_pkg::RATIO_0;
    end else if (I_CE) begin
      O_PRECHARGE_MV  <= 13'(chgcfg_pkg::PREV_BASE_MV
                         + chgcfg_pkg::PREV_STEP_MV * 13'(prev_code));
      O_PRECHARGE_PCT <= ratio(ctrl_sec_r[chgcfg_pkg::PREI_LSB +: 2]);
      O_DONE_PCT      <= ratio(ctrl_sec_r[chgcfg_pkg::DONE_LSB +: 2]);
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_MAINTAIN_MIN <= chgcfg_pkg::MT_MIN_0;
      O_FAST_MIN     <= chgcfg_pkg::FC_MIN_BASE;
      O_PRE_MIN      <= chgcfg_pkg::PC_MIN_BASE;
    end else if (I_CE) begin
      O_MAINTAIN_MIN <= mt_min(timer_r[chgcfg_pkg::MT_TMR_LSB +: 2]);
      O_FAST_MIN     <= chgcfg_pkg::FC_MIN_BASE
                        << timer_r[chgcfg_pkg::FC_TMR_LSB +: 2];
      O_PRE_MIN      <= chgcfg_pkg::PC_MIN_BASE
                        << timer_r[chgcfg_pkg::PC_TMR_LSB +: 2];
    end
  end

  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  // write path
  wp_blocks_write_a: assert property (
      (I_CE && I_WR && wp_r && !supply_rise && I_ADDR == chgcfg_pkg::CTRL_PRI_ADDR)
      |=> $stable(ctrl_pri_r))
    else $error("protected primary register changed");

  pri_write_a: assert property (
      (I_CE && I_WR && !wp_r && !supply_rise && I_ADDR == chgcfg_pkg::CTRL_PRI_ADDR)
      |=> ctrl_pri_r == $past(I_WDATA))
    else $error("primary write lost");

  sec_write_a: assert property (
      (I_CE && I_WR && !supply_rise && I_ADDR == chgcfg_pkg::CTRL_SEC_ADDR)
      |=> ctrl_sec_r == ($past(I_WDATA) & chgcfg_pkg::CTRL_SEC_MASK))
    else $error("secondary write wrong");

  timer_write_a: assert property (
      (I_CE && I_WR && !supply_rise && I_ADDR == chgcfg_pkg::TIMER_ADDR)
      |=> timer_r == ($past(I_WDATA) & chgcfg_pkg::TIMER_MASK))
    else $error("timer write wrong");

  unused_zero_a: assert property (ctrl_sec_r[7] == 1'b0 && timer_r[7:6] == 2'h0)
    else $error("unused bits set");

  // read port
  rdata_pri_a: assert property (
      (I_CE && I_RD && I_ADDR == chgcfg_pkg::CTRL_PRI_ADDR) |=> O_RDATA == $past(ctrl_pri_r))
    else $error("primary read back wrong");

  rdata_sec_a: assert property (
      (I_CE && I_RD && I_ADDR == chgcfg_pkg::CTRL_SEC_ADDR)
      |=> O_RDATA == $past(ctrl_sec_r) && O_RDATA[7] == 1'b0)
    else $error("secondary read back wrong");

  rdata_timer_a: assert property (
      (I_CE && I_RD && I_ADDR == chgcfg_pkg::TIMER_ADDR)
      |=> O_RDATA == $past(timer_r) && O_RDATA[7:6] == 2'h0)
    else $error("timer read back wrong");

  // supply default
  supply_reset_a: assert property (
      (I_CE && supply_rise) |=> (ctrl_pri_r == chgcfg_pkg::CTRL_PRI_RST
      && ctrl_sec_r == chgcfg_pkg::CTRL_SEC_RST && timer_r == chgcfg_pkg::TIMER_RST))
    else $error("registers not defaulted on supply rise");

  supply_pulse_a: assert property ((I_CE && supply_rise) |=> !supply_rise)
    else $error("supply edge pulse too long");

  supply_outs_a: assert property (
      (I_CE && supply_rise) ##1 I_CE |=> (!O_AUTO_STOP_ENABLE && !O_AUTO_RESTART_ENABLE
      && !O_CHARGER_ON))
    else $error("outputs not defaulted on supply rise");

  // decoded fields
  auto_stop_a: assert property (I_CE |=> O_AUTO_STOP_ENABLE == $past(ctrl_pri_r[7]))
    else $error("auto stop mismatch");
  auto_restart_a: assert property (I_CE |=> O_AUTO_RESTART_ENABLE == $past(ctrl_pri_r[6]))
    else $error("auto restart mismatch");
  charger_on_a: assert property (I_CE |=> O_CHARGER_ON == $past(ctrl_pri_r[0]))
    else $error("charger on mismatch");

  battery_regulation_sel_range_a: assert property (
      O_BATTERY_REGULATION_SEL_VALID |-> (O_BATTERY_REGULATION_SEL_MV >= 13'd4050 && O_BATTERY_REGULATION_SEL_MV <= 13'd4350))
    else $error("regulation out of range");

  battery_regulation_sel_map_a: assert property (
      (I_CE && battery_regulation_sel_code != chgcfg_pkg::BATTERY_REGULATION_SEL_RSVD)
      |=> O_BATTERY_REGULATION_SEL_VALID && O_BATTERY_REGULATION_SEL_MV == 13'd4050 + 13'd50 * {10'h000, $past(battery_regulation_sel_code)})
    else $error("regulation value wrong");

  battery_regulation_sel_rsvd_a: assert property (
      (I_CE && battery_regulation_sel_code == chgcfg_pkg::BATTERY_REGULATION_SEL_RSVD) |=> !O_BATTERY_REGULATION_SEL_VALID)
    else $error("reserved regulation code not flagged");

  prev_range_a: assert property (
      O_PRECHARGE_MV >= 13'd2100 && O_PRECHARGE_MV <= 13'd3150)
    else $error("pre-charge threshold out of range");

  prev_map_a: assert property (
      I_CE |=> O_PRECHARGE_MV == 13'd2100 + 13'd150 * {10'h000, $past(prev_code)})
    else $error("pre-charge threshold wrong");

  ratio_set_a: assert property (
      O_DONE_PCT inside {6'd5, 6'd10, 6'd20, 6'd30}
      && O_PRECHARGE_PCT inside {6'd5, 6'd10, 6'd20, 6'd30})
    else $error("current ratio illegal");

  prei_map_a: assert property (
      I_CE |=> O_PRECHARGE_PCT == ($past(ctrl_sec_r[3])
      ? ($past(ctrl_sec_r[2]) ? 6'd30 : 6'd20)
      : ($past(ctrl_sec_r[2]) ? 6'd10 : 6'd5)))
    else $error("pre-charge current wrong");

  done_map_a: assert property (
      I_CE |=> O_DONE_PCT == ($past(ctrl_sec_r[1])
      ? ($past(ctrl_sec_r[0]) ? 6'd30 : 6'd20)
      : ($past(ctrl_sec_r[0]) ? 6'd10 : 6'd5)))
    else $error("done threshold wrong");

  maintain_map_a: assert property (
      I_CE |=> O_MAINTAIN_MIN == ($past(timer_r[5])
      ? ($past(timer_r[4]) ? 10'd60 : 10'd30)
      : ($past(timer_r[4]) ? 10'd15 : 10'd0)))
    else $error("maintain timer wrong");

  fast_range_a: assert property (
      O_FAST_MIN inside {10'd75, 10'd150, 10'd300, 10'd600}
      && O_PRE_MIN inside {10'd30, 10'd60, 10'd120, 10'd240})
    else $error("timer value illegal");

  fast_map_a: assert property (
      I_CE |=> O_FAST_MIN == ($past(timer_r[3])
      ? ($past(timer_r[2]) ? 10'd600 : 10'd300)
      : ($past(timer_r[2]) ? 10'd150 : 10'd75)))
    else $error("fast timer wrong");

  pre_map_a: assert property (
      I_CE |=> O_PRE_MIN == ($past(timer_r[1])
      ? ($past(timer_r[0]) ? 10'd240 : 10'd120)
      : ($past(timer_r[0]) ? 10'd60 : 10'd30)))
    else $error("pre timer wrong");

  wp_block_c: cover property (I_WR && wp_r && I_ADDR == chgcfg_pkg::CTRL_PRI_ADDR);
  supply_rise_c: cover property (supply_rise);
  rsvd_reg_c: cover property (!O_BATTERY_REGULATION_SEL_VALID);
  read_back_c: cover property (I_RD && I_ADDR == chgcfg_pkg::TIMER_ADDR);
  ce_hold_c: cover property (!I_CE && I_WR);
endmodule
`default_nettype wire

// >>> test/tb_chgcfg_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_chgcfg_regs;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        wp;
  logic        supply;
  logic [7:0]  rdata;
  logic        auto_stop;
  logic        auto_restart;
  logic [1:0]  rechg_sel;
  logic        battery_regulation_sel_valid;
  logic [12:0] battery_regulation_sel_mv;
  logic        charger_on;
  logic [12:0] pre_mv;
  logic [5:0]  pre_pct;
  logic [5:0]  done_pct;
  logic [9:0]  mt_min;
  logic [9:0]  fc_min;
  logic [9:0]  pc_min;
  logic [7:0]  exp_r [3];
  logic [7:0]  d;
  int          err_count;
  int          tests_run;
  int          seed;

  chgcfg_regs dut_u (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .I_WRITE_PROTECT(wp), .I_CHARGER_INPUT_SUPPLY(supply),
    .O_RDATA(rdata), .O_AUTO_STOP_ENABLE(auto_stop), .O_AUTO_RESTART_ENABLE(auto_restart),
    .O_RECHARGE_THRESHOLD_SEL(rechg_sel), .O_BATTERY_REGULATION_SEL_VALID(battery_regulation_sel_valid),
    .O_BATTERY_REGULATION_SEL_MV(battery_regulation_sel_mv), .O_CHARGER_ON(charger_on), .O_PRECHARGE_MV(pre_mv),
    .O_PRECHARGE_PCT(pre_pct), .O_DONE_PCT(done_pct), .O_MAINTAIN_MIN(mt_min),
    .O_FAST_MIN(fc_min), .O_PRE_MIN(pc_min));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [12:0] ratio(input logic [1:0] c);
    return (c == 2'h0) ? 13'h0005 : 13'(13'h000a * c);
  endfunction

  task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] expv);
    tests_run++;
    if (seen !== expv) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wrx(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    if (a == 8'h0a && !wp) exp_r[0] = v;
    if (a == 8'h0b) exp_r[1] = v & chgcfg_pkg::CTRL_SEC_MASK;
    if (a == 8'h0c) exp_r[2] = v & chgcfg_pkg::TIMER_MASK;
  endtask

  task automatic rdx(input logic [7:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
    @(posedge clk);
    chk("rdata idle", rdata, 13'h0000);
  endtask

  task automatic check_regs();
    logic [7:0] v;
    for (int i = 0; i < 3; i++) begin
      rdx(8'h0a + 8'(i), v);
      chk("register", v, exp_r[i]);
    end
  endtask

  task automatic check_outs();
    logic [2:0] bc;
    bc = exp_r[0][3:1];
    chk("auto_stop", auto_stop, exp_r[0][7]);
    chk("auto_restart", auto_restart, exp_r[0][6]);
    chk("recharge_sel", rechg_sel, exp_r[0][5:4]);
    chk("battery_regulation_sel_valid", battery_regulation_sel_valid, bc != 3'h7);
    if (bc != 3'h7) chk("battery_regulation_sel_mv", battery_regulation_sel_mv, 13'(13'h0fd2 + 13'h0032 * bc));
    chk("charger_on", charger_on, exp_r[0][0]);
    chk("precharge_mv", pre_mv, 13'(13'h0834 + 13'h0096 * exp_r[1][6:4]));
    chk("precharge_pct", pre_pct, ratio(exp_r[1][3:2]));
    chk("done_pct", done_pct, ratio(exp_r[1][1:0]));
    chk("maintain_min", mt_min, (exp_r[2][5:4] == 2'h0) ? 13'h0000
        : 13'(13'h000f << (exp_r[2][5:4] - 2'h1)));
    chk("fast_min", fc_min, 13'(13'h004b << exp_r[2][3:2]));
    chk("pre_min", pc_min, 13'(13'h001e << exp_r[2][1:0]));
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    test_done();
  end

  initial begin
    seed = 32'h08fe;
    {rst_n, addr, wdata, wr, rd, wp, supply} = '0;
    ce = 1'b1;
    err_count = 0;
    tests_run = 0;
    foreach (exp_r[i]) exp_r[i] = 8'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_regs();
    check_outs();
    $display("test reset values done");
    for (int i = 0; i < 30; i++) begin
      d = (i < 3) ? 8'hff : 8'($random(seed));
      wrx(8'h0a + 8'(i % 3), d);
      check_regs();
      check_outs();
    end
    for (int c = 0; c < 8; c++) begin
      wrx(8'h0a, (8'($random(seed)) & 8'hf1) | 8'(c << 1));
      @(posedge clk);
      check_outs();
    end
    $display("test random writes done");
    wp <= 1'b1;
    repeat (4) @(posedge clk);
    wrx(8'h0a, ~exp_r[0]);
    wrx(8'h0b, 8'($random(seed)));
    check_regs();
    check_outs();
    wp <= 1'b0;
    repeat (4) @(posedge clk);
    wrx(8'h0a, ~exp_r[0]);
    check_regs();
    $display("test write protect done");
    ce <= 1'b0;
    d = exp_r[1];
    wrx(8'h0b, ~d);
    exp_r[1] = d;
    ce <= 1'b1;
    check_regs();
    check_outs();
    $display("test clock enable done");
    wrx(8'h0d, 8'hff);
    wrx(8'h09, 8'hff);
    rdx(8'h0d, d);
    chk("unmapped read", d, 13'h0000);
    rdx(8'h00, d);
    chk("unmapped read", d, 13'h0000);
    check_regs();
    $display("test unmapped done");
    wrx(8'h0a, 8'hff);
    wrx(8'h0b, 8'h7f);
    wrx(8'h0c, 8'h3f);
    supply <= 1'b1;
    repeat (3) @(posedge clk);
    wrx(8'h0b, 8'h55);
    repeat (3) @(posedge clk);
    foreach (exp_r[i]) exp_r[i] = 8'h00;
    check_regs();
    check_outs();
    wrx(8'h0c, 8'h2d);
    supply <= 1'b0;
    repeat (8) @(posedge clk);
    check_regs();
    $display("test supply edge done");
    wrx(8'h0a, 8'hff);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (exp_r[i]) exp_r[i] = 8'h00;
    check_regs();
    check_outs();
    $display("test mid reset done");
    test_done();
  end
endmodule
`default_nettype wire
